// ### iosd_map.vh
`ifndef IOSD_MAP_VH
`define IOSD_MAP_VH
// ----------------------------------------
// i/o space geometry
// ----------------------------------------
`define IOSD_IO_LAST        6'h3f
`define IOSD_BIT_LAST       6'h1f
`define IOSD_DATA_OFFSET    8'h20
`define IOSD_EXT_FIRST      8'h60
`define IOSD_EXT_LAST       8'hff
`define IOSD_IO_COUNT       64
// ----------------------------------------
// register offsets (i/o addresses)
// ----------------------------------------
`define IOSD_PORT_B_OUTPUT_LATCH_IN       6'h03
`define IOSD_PORT_B_OUTPUT_LATCH_DIR      6'h04
`define IOSD_PORT_B_OUTPUT_LATCH_OUT      6'h05
`define IOSD_PORT_C_OUTPUT_LATCH_IN       6'h06
`define IOSD_PORT_C_OUTPUT_LATCH_DIR      6'h07
`define IOSD_PORT_C_OUTPUT_LATCH_OUT      6'h08
`define IOSD_PORT_D_OUTPUT_LATCH_IN       6'h09
`define IOSD_PORT_D_OUTPUT_LATCH_DIR      6'h0a
`define IOSD_PORT_D_OUTPUT_LATCH_OUT      6'h0b
`define IOSD_T0_FLAGS       6'h15
`define IOSD_PC_FLAGS       6'h1b
`define IOSD_EXT_FLAGS      6'h1c
`define IOSD_EXT_MASK       6'h1d
`define IOSD_SCRATCH0       6'h1e
`define IOSD_NV_CTRL        6'h1f
`define IOSD_NV_DATA        6'h20
`define IOSD_NV_ADDR_LO     6'h21
`define IOSD_NV_ADDR_HI     6'h22
`define IOSD_PRESCALE_CTRL  6'h23
`define IOSD_T0_CTRL_A      6'h24
`define IOSD_T0_CTRL_B      6'h25
`define IOSD_T0_COUNT       6'h26
// ----------------------------------------
// implemented bit masks
// ----------------------------------------
`define IOSD_MASK_FULL      8'hff
`define IOSD_MASK_PORT_C_OUTPUT_LATCH     8'h7f
`define IOSD_MASK_T0_FLAGS  8'h07
`define IOSD_MASK_PC_FLAGS  8'h07
`define IOSD_MASK_EXT_FLAGS 8'h03
`define IOSD_MASK_EXT_MASK  8'h03
`define IOSD_MASK_NV_CTRL   8'h3f
`define IOSD_MASK_PRESCALE  8'h83
`define IOSD_MASK_T0_CTRL_B 8'hcf
`define IOSD_RESET_VALUE    8'h00
// ----------------------------------------
// access operation codes
// ----------------------------------------
`define IOSD_OP_NONE        3'h0
`define IOSD_OP_IN          3'h1
`define IOSD_OP_OUT         3'h2
`define IOSD_OP_LOAD        3'h3
`define IOSD_OP_STORE       3'h4
`define IOSD_OP_SETBIT      3'h5
`define IOSD_OP_CLRBIT      3'h6
`define IOSD_OP_TESTBIT     3'h7
`endif

// ### iosd_addr_decode.v
`timescale 1ns/1ps
`include "iosd_map.vh"
// ----------------------------------------
// maps an access onto an i/o index
// ----------------------------------------
module iosd_addr_decode (
   // request
   input  wire [2:0] op,
   input  wire [7:0] addr,
   // decoded result
   output reg  [5:0] io_index,
   output reg        io_hit,
   output reg        ext_hit
);
   // port ops use the 6-bit field; data ops subtract the offset
   always @* begin
      io_index = 6'h00;
      io_hit   = 1'b0;
      ext_hit  = 1'b0;
      case (op)
         `IOSD_OP_IN, `IOSD_OP_OUT: begin
            io_index = addr[5:0];
            io_hit   = 1'b1;
         end
         `IOSD_OP_SETBIT, `IOSD_OP_CLRBIT, `IOSD_OP_TESTBIT: begin
            io_index = addr[5:0];
            io_hit   = (addr[5:0] <= `IOSD_BIT_LAST);
         end
         `IOSD_OP_LOAD, `IOSD_OP_STORE: begin
            if (addr >= `IOSD_EXT_FIRST) begin
               ext_hit = 1'b1;
            end else if (addr >= `IOSD_DATA_OFFSET) begin
               io_index = addr[5:0] - 6'h20;
               io_hit   = 1'b1;
            end
         end
         default: begin
            io_hit = 1'b0;
         end
      endcase
   end
endmodule // iosd_addr_decode

// ### iosd_io_space.v
`timescale 1ns/1ps
`include "iosd_map.vh"
// Behaviour
// - bit set/clear only at 0x00-0x1F
// - skip instructions test one low-range bit
// - status flags clear on written one
// - bit instruction changes only addressed bit
// - port instructions use addresses 0x00-0x3F
// - data address is i/o address plus 0x20
// - extended region only by load/store
// - port field covers exactly 64 locations
module iosd_io_space (
   // clock and reset
   input  wire       core_clk,
   input  wire       reset,
   // access from the core
   input  wire [2:0] op,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire [2:0] bit_sel,
   output reg  [7:0] rdata,
   output reg        bit_value,
   output wire       ext_access,
   // peripheral pins and events
   input  wire [7:0] port_b_pins,
   input  wire [6:0] port_c_pins,
   input  wire [7:0] port_d_pins,
   input  wire [2:0] timer0_event_set,
   input  wire [2:0] pin_change_set,
   input  wire [1:0] external_irq_set,
   // register contents to peripherals
   output wire [7:0] port_b_dir,
   output wire [7:0] port_b_out,
   output wire [6:0] port_c_dir,
   output wire [6:0] port_c_out,
   output wire [7:0] port_d_dir,
   output wire [7:0] port_d_out,
   output wire [2:0] timer0_flags,
   output wire [2:0] pin_flags,
   output wire [1:0] ext_flags,
   output wire [1:0] ext_mask
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg  [7:0] regs [0:`IOSD_IO_COUNT-1];
   reg  [7:0] sync_b1;
   reg  [7:0] sync_b2;
   reg  [6:0] sync_c1;
   reg  [6:0] sync_c2;
   reg  [7:0] sync_d1;
   reg  [7:0] sync_d2;
   wire [5:0] io_index;
   wire       io_hit;
   wire       ext_hit;
   reg  [7:0] cur;
   reg  [7:0] next_val;
   reg  [7:0] clear_ones;
   reg        do_write;
   integer    i;

   // implemented bits of each location; zero marks unused
   function [7:0] impl_mask;
      input [5:0] idx;
      begin
         case (idx)
            `IOSD_PORT_B_OUTPUT_LATCH_IN, `IOSD_PORT_B_OUTPUT_LATCH_DIR, `IOSD_PORT_B_OUTPUT_LATCH_OUT,
            `IOSD_PORT_D_OUTPUT_LATCH_IN, `IOSD_PORT_D_OUTPUT_LATCH_DIR, `IOSD_PORT_D_OUTPUT_LATCH_OUT,
            `IOSD_SCRATCH0, `IOSD_NV_DATA, `IOSD_NV_ADDR_LO,
            `IOSD_NV_ADDR_HI, `IOSD_T0_CTRL_A, `IOSD_T0_COUNT:
               impl_mask = `IOSD_MASK_FULL;
            `IOSD_PORT_C_OUTPUT_LATCH_IN, `IOSD_PORT_C_OUTPUT_LATCH_DIR, `IOSD_PORT_C_OUTPUT_LATCH_OUT:
               impl_mask = `IOSD_MASK_PORT_C_OUTPUT_LATCH;
            `IOSD_T0_FLAGS:      impl_mask = `IOSD_MASK_T0_FLAGS;
            `IOSD_PC_FLAGS:      impl_mask = `IOSD_MASK_PC_FLAGS;
            `IOSD_EXT_FLAGS:     impl_mask = `IOSD_MASK_EXT_FLAGS;
            `IOSD_EXT_MASK:      impl_mask = `IOSD_MASK_EXT_MASK;
            `IOSD_NV_CTRL:       impl_mask = `IOSD_MASK_NV_CTRL;
            `IOSD_PRESCALE_CTRL: impl_mask = `IOSD_MASK_PRESCALE;
            `IOSD_T0_CTRL_B:     impl_mask = `IOSD_MASK_T0_CTRL_B;
            default:             impl_mask = 8'h00;
         endcase
      end
   endfunction

   // write-one-to-clear locations
   function is_w1c;
      input [5:0] idx;
      begin
         is_w1c = (idx == `IOSD_T0_FLAGS) || (idx == `IOSD_PC_FLAGS) ||
                  (idx == `IOSD_EXT_FLAGS);
      end
   endfunction

   // pin-level locations are read only
   function is_pin;
      input [5:0] idx;
      begin
         is_pin = (idx == `IOSD_PORT_B_OUTPUT_LATCH_IN) || (idx == `IOSD_PORT_C_OUTPUT_LATCH_IN) ||
                  (idx == `IOSD_PORT_D_OUTPUT_LATCH_IN);
      end
   endfunction

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   iosd_addr_decode u_decode (
      .op       (op),
      .addr     (addr),
      .io_index (io_index),
      .io_hit   (io_hit),
      .ext_hit  (ext_hit)
   );

   assign ext_access = ext_hit;   // extended region handled outside

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync_b1 <= 8'h00;
         sync_b2 <= 8'h00;
         sync_c1 <= 7'h00;
         sync_c2 <= 7'h00;
         sync_d1 <= 8'h00;
         sync_d2 <= 8'h00;
      end else begin
         sync_b1 <= port_b_pins;
         sync_b2 <= sync_b1;
         sync_c1 <= port_c_pins;
         sync_c2 <= sync_c1;
         sync_d1 <= port_d_pins;
         sync_d2 <= sync_d1;
      end
   end

   // ----------------------------------------
   // read and write value computation
   // ----------------------------------------
   // stored value, or synchronised pins for input locations
   always @* begin
      case (io_index)
         `IOSD_PORT_B_OUTPUT_LATCH_IN: cur = sync_b2;
         `IOSD_PORT_C_OUTPUT_LATCH_IN: cur = {1'b0, sync_c2};
         `IOSD_PORT_D_OUTPUT_LATCH_IN: cur = sync_d2;
         default:        cur = regs[io_index];
      endcase
   end

   // next value and the ones to clear in flag registers
   always @* begin
      next_val   = regs[io_index];
      clear_ones = 8'h00;
      do_write   = 1'b0;
      if (io_hit && !is_pin(io_index) && impl_mask(io_index) != 8'h00) begin
         case (op)
            `IOSD_OP_OUT, `IOSD_OP_STORE: begin
               do_write = 1'b1;
               if (is_w1c(io_index))
                  clear_ones = wdata & impl_mask(io_index);
               else
                  next_val = wdata & impl_mask(io_index);
            end
            `IOSD_OP_SETBIT: begin
               do_write = 1'b1;
               // flags: setting a bit writes one to that bit alone
               if (is_w1c(io_index))
                  clear_ones = (8'h01 << bit_sel) & impl_mask(io_index);
               else
                  next_val = (regs[io_index] | (8'h01 << bit_sel))
                             & impl_mask(io_index);
            end
            `IOSD_OP_CLRBIT: begin
               do_write = 1'b1;
               // flags: a zero write clears nothing
               if (!is_w1c(io_index))
                  next_val = regs[io_index] & ~(8'h01 << bit_sel);
            end
            default: begin
               do_write = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // register storage with event set priority
   // ----------------------------------------
   // a set arriving with a clear wins
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (i = 0; i < `IOSD_IO_COUNT; i = i + 1)
            regs[i] <= `IOSD_RESET_VALUE;
      end else begin
         if (do_write && !is_w1c(io_index))
            regs[io_index] <= next_val;
         regs[`IOSD_T0_FLAGS] <= (regs[`IOSD_T0_FLAGS] &
            ~((io_index == `IOSD_T0_FLAGS) ? clear_ones : 8'h00)) |
            {5'h00, timer0_event_set};
         regs[`IOSD_PC_FLAGS] <= (regs[`IOSD_PC_FLAGS] &
            ~((io_index == `IOSD_PC_FLAGS) ? clear_ones : 8'h00)) |
            {5'h00, pin_change_set};
         regs[`IOSD_EXT_FLAGS] <= (regs[`IOSD_EXT_FLAGS] &
            ~((io_index == `IOSD_EXT_FLAGS) ? clear_ones : 8'h00)) |
            {6'h00, external_irq_set};
      end
   end

   // ----------------------------------------
   // read data and bit test
   // ----------------------------------------
   // read data registered one cycle after the request
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rdata     <= 8'h00;
         bit_value <= 1'b0;
      end else begin
         if (io_hit && (op == `IOSD_OP_IN || op == `IOSD_OP_LOAD))
            rdata <= cur & impl_mask(io_index);
         else
            rdata <= 8'h00;
         if (io_hit && op == `IOSD_OP_TESTBIT)
            bit_value <= |((cur & impl_mask(io_index)) & (8'h01 << bit_sel));
         else
            bit_value <= 1'b0;
      end
   end

   // ----------------------------------------
   // register contents to peripherals
   // ----------------------------------------
   assign port_b_dir   = regs[`IOSD_PORT_B_OUTPUT_LATCH_DIR];
   assign port_b_out   = regs[`IOSD_PORT_B_OUTPUT_LATCH_OUT];
   assign port_c_dir   = regs[`IOSD_PORT_C_OUTPUT_LATCH_DIR][6:0];
   assign port_c_out   = regs[`IOSD_PORT_C_OUTPUT_LATCH_OUT][6:0];
   assign port_d_dir   = regs[`IOSD_PORT_D_OUTPUT_LATCH_DIR];
   assign port_d_out   = regs[`IOSD_PORT_D_OUTPUT_LATCH_OUT];
   assign timer0_flags = regs[`IOSD_T0_FLAGS][2:0];
   assign pin_flags    = regs[`IOSD_PC_FLAGS][2:0];
   assign ext_flags    = regs[`IOSD_EXT_FLAGS][1:0];
   assign ext_mask     = regs[`IOSD_EXT_MASK][1:0];
endmodule // iosd_io_space

// ### iosd_io_space_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// checker on the i/o space ports
// ----------------------------------------
module iosd_io_space_chk (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // core access
   input wire logic [2:0] op,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] rdata,
   input wire logic       bit_value,
   input wire logic       ext_access,
   // flags and latches
   input wire logic [1:0] external_irq_set,
   input wire logic [7:0] port_b_out,
   input wire logic [1:0] ext_flags
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // port and data space paths to one latch; extended region flag
   AST_OUT_B: assert property (op == 3'h2 && addr[5:0] == 6'h05 |=> port_b_out == $past(wdata))
      else $error("port write lost");
   AST_IN_B: assert property (op == 3'h1 && addr[5:0] == 6'h05 |=> rdata == $past(port_b_out))
      else $error("port read wrong");
   AST_STORE_OFS: assert property (op == 3'h4 && addr == 8'h25 |=> port_b_out == $past(wdata))
      else $error("store at offset lost");
   AST_EXT_ONLY: assert property (ext_access == ((op == 3'h3 || op == 3'h4) && addr >= 8'h60))
      else $error("extended flag wrong");
   // write-one-to-clear flags
   AST_W1C: assert property (op == 3'h2 && addr[5:0] == 6'h1c && wdata[0] && !external_irq_set[0]
      |=> !ext_flags[0])
      else $error("flag not cleared");
   AST_W0_KEEP: assert property (op == 3'h2 && addr[5:0] == 6'h1c && !wdata[1] && ext_flags[1]
      |=> ext_flags[1])
      else $error("flag lost on zero");
   // single-bit operations
   AST_SETB: assert property (op == 3'h5 && addr[5:0] == 6'h05
      |=> port_b_out == ($past(port_b_out) | (8'h01 << $past(bit_sel))))
      else $error("bit set wrong");
   AST_TESTB: assert property (op == 3'h7 && addr[5:0] == 6'h05 |=> bit_value == $past(port_b_out[bit_sel]))
      else $error("bit test wrong");
   AST_TEST_HI: assert property (op == 3'h7 && addr[5:0] > 6'h1f |=> !bit_value)
      else $error("bit test above range");
endmodule // iosd_io_space_chk

bind iosd_io_space iosd_io_space_chk i_chk (.core_clk, .reset, .op, .addr, .wdata, .bit_sel, .rdata, .bit_value,
   .ext_access, .external_irq_set, .port_b_out, .ext_flags);

// ### iosd_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core execution unit issuing accesses
// ----------------------------------------
module iosd_core_model (
   // clock
   input wire logic       core_clk,
   // access to the i/o space
   output logic     [2:0] op,
   output logic     [7:0] addr,
   output logic     [7:0] wdata,
   output logic     [2:0] bit_sel
);
   // idle request at time zero
   initial begin
      op = 3'h0;
      addr = 8'h00;
      wdata = 8'h00;
      bit_sel = 3'h0;
   end
   // one access just after an edge; callers may set unused bits (0xff to 0x08)
   // but never write unused locations
   task automatic issue(input logic [2:0] o, input logic [7:0] a, d, input logic [2:0] b);
      @(posedge core_clk);
      #1;
      op = o;
      addr = a;
      wdata = d;
      bit_sel = b;
   endtask
   // released address and data lines show changing garbage
   task automatic idle();
      @(posedge core_clk);
      #1;
      op = 3'h0;
      addr = ~addr;
      wdata = ~wdata;
   endtask
endmodule // iosd_core_model

// ### io_space_register_decoder_tb_top.sv
`timescale 1ns/1ps
module io_space_register_decoder_tb_top;
   typedef struct {logic [2:0] o; logic [7:0] a, d; logic [2:0] b; logic [7:0] e;} iosd_row_t;
   logic       core_clk = 1'b0, reset = 1'b1;
   logic [7:0] port_b_pins = 8'h3c, port_d_pins = 8'hc3;
   logic [6:0] port_c_pins = 7'h15;
   logic [2:0] timer0_event_set = 3'h0, pin_change_set = 3'h0;
   logic [1:0] external_irq_set = 2'h0;
   wire  [2:0] op, bit_sel, timer0_flags, pin_flags;
   wire  [7:0] addr, wdata, rdata, port_b_out;
   wire  [1:0] ext_flags;
   wire        bit_value, ext_access;
   int         fails = 0, num_checks = 0;
   iosd_row_t  rows [22] = '{
      '{3'h2, 8'h05, 8'ha5, 3'h0, 8'h00}, '{3'h1, 8'h05, 8'h00, 3'h0, 8'ha5},
      '{3'h4, 8'h25, 8'h3c, 3'h0, 8'h00}, '{3'h1, 8'h05, 8'h00, 3'h0, 8'h3c},
      '{3'h3, 8'h05, 8'h00, 3'h0, 8'h00}, '{3'h2, 8'h26, 8'h77, 3'h0, 8'h00},
      '{3'h3, 8'h46, 8'h00, 3'h0, 8'h77}, '{3'h1, 8'h03, 8'h00, 3'h0, 8'h3c},
      '{3'h3, 8'h26, 8'h00, 3'h0, 8'h15}, '{3'h1, 8'h09, 8'h00, 3'h0, 8'hc3},
      '{3'h1, 8'h02, 8'h00, 3'h0, 8'h00}, '{3'h2, 8'h08, 8'hff, 3'h0, 8'h00},
      '{3'h1, 8'h08, 8'h00, 3'h0, 8'h7f}, '{3'h5, 8'h05, 8'h00, 3'h6, 8'h00},
      '{3'h1, 8'h05, 8'h00, 3'h0, 8'h7c}, '{3'h6, 8'h05, 8'h00, 3'h2, 8'h00},
      '{3'h1, 8'h05, 8'h00, 3'h0, 8'h78}, '{3'h7, 8'h05, 8'h00, 3'h4, 8'h01},
      '{3'h7, 8'h05, 8'h00, 3'h0, 8'h00}, '{3'h2, 8'h24, 8'h01, 3'h0, 8'h00},
      '{3'h5, 8'h24, 8'h00, 3'h1, 8'h00}, '{3'h1, 8'h24, 8'h00, 3'h0, 8'h01}};
   always #5 core_clk = ~core_clk;
   iosd_core_model i_core (.core_clk(core_clk), .op(op), .addr(addr), .wdata(wdata), .bit_sel(bit_sel));
   iosd_io_space i_dut (.core_clk(core_clk), .reset(reset), .op(op), .addr(addr), .wdata(wdata),
      .bit_sel(bit_sel), .rdata(rdata), .bit_value(bit_value), .ext_access(ext_access),
      .port_b_pins(port_b_pins), .port_c_pins(port_c_pins), .port_d_pins(port_d_pins),
      .timer0_event_set(timer0_event_set), .pin_change_set(pin_change_set),
      .external_irq_set(external_irq_set), .port_b_dir(), .port_b_out(port_b_out), .port_c_dir(),
      .port_c_out(), .port_d_dir(), .port_d_out(), .timer0_flags(timer0_flags), .pin_flags(pin_flags),
      .ext_flags(ext_flags), .ext_mask());
   // comparisons
   task automatic chk8(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one access followed by an idle cycle
   task automatic acc(input logic [2:0] o, input logic [7:0] a, d, input logic [2:0] b);
      i_core.issue(o, a, d, b);
      i_core.idle();
   endtask
   task automatic ext_chk(input logic [2:0] o, input logic [7:0] a, input logic e);
      i_core.issue(o, a, 8'h00, 3'h0);
      #1;
      chk1(ext_access, e);
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      reset = 1'b0;
      foreach (rows[i]) begin
         acc(rows[i].o, rows[i].a, rows[i].d, rows[i].b);
         if (rows[i].o == 3'h7)
            chk1(bit_value, rows[i].e[0]);
         else
            chk8(rdata, rows[i].e);
      end
      $display("table test done");
      @(posedge core_clk);
      #1;
      {timer0_event_set, pin_change_set, external_irq_set} = 8'hff;
      @(posedge core_clk);
      #1;
      {timer0_event_set, pin_change_set, external_irq_set} = 8'h00;
      chk8({timer0_flags, pin_flags, ext_flags}, 8'hff);
      acc(3'h2, 8'h1c, 8'h01, 3'h0);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'hfe);
      acc(3'h2, 8'h1c, 8'h00, 3'h0);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'hfe);
      acc(3'h4, 8'h35, 8'h05, 3'h0);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'h5e);
      acc(3'h5, 8'h1b, 8'h00, 3'h2);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'h4e);
      acc(3'h6, 8'h1c, 8'h00, 3'h1);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'h4e);
      $display("flag test done");
      ext_chk(3'h3, 8'h60, 1'b1);
      ext_chk(3'h4, 8'hff, 1'b1);
      ext_chk(3'h3, 8'h5f, 1'b0);
      ext_chk(3'h1, 8'h60, 1'b0);
      i_core.idle();
      $display("extended test done");
      reset = 1'b1;
      #1;
      chk8(port_b_out, 8'h00);
      chk8({timer0_flags, pin_flags, ext_flags}, 8'h00);
      @(posedge core_clk);
      #1;
      reset = 1'b0;
      $display("reset test done");
      wrap_up();
   end
endmodule // io_space_register_decoder_tb_top
